/* File: design/serial_buffer_status_flags.v */
`timescale 1ns/1ps
`include "serial_buffer_status_flags_defs.vh"

module serial_buffer_status_flags (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        tx_load_shifter,
    input  wire        tx_shift_done,
    input  wire        rx_word_done,
    input  wire [7:0]  rx_shift_word,
    output reg  [7:0]  tx_shift_word,
    output reg         tx_start,
    output reg         double_buffer_enable,
    output reg         stop_len_two,
    output reg         msb_first,
    output reg         soft_reset_pulse,
    output reg         irq
);

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    function addr_hit;
        input [11:0] a;
        input [11:0] off;
        begin
            addr_hit = (a == off);
        end
    endfunction

    wire setup    = psel & ~penable;
    wire wr_stb   = setup & pwrite;
    wire rd_stb   = setup & ~pwrite;
    wire hit_mod  = addr_hit(paddr, `MODE_CTRL_TWO_OFFSET);
    wire hit_sts  = addr_hit(paddr, `IRQ_STATUS_OFFSET);
    wire hit_msk  = addr_hit(paddr, `IRQ_MASK_OFFSET);
    wire hit_txd  = addr_hit(paddr, `TX_DATA_OFFSET);
    wire hit_rxd  = addr_hit(paddr, `RX_DATA_OFFSET);
    wire hit_shf  = addr_hit(paddr, `SHIFTER_OFFSET);
    wire hit_any  = hit_mod | hit_sts | hit_msk | hit_txd | hit_rxd | hit_shf;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg         tx_empty_q;
    reg         rx_full_q;
    reg         tx_run_q;
    reg  [1:0]  soft_rst_q;
    reg  [7:0]  tx_buf_q;
    reg  [7:0]  rx_buf_q;
    reg  [2:0]  irq_status_q;
    reg  [2:0]  irq_mask_q;

    // Writes take effect in the setup cycle, so the slave answers one cycle later.
    wire tx_write   = wr_stb & hit_txd;
    wire rx_read    = rd_stb & hit_rxd;
    wire mod_write  = wr_stb & hit_mod;
    wire soft_reset = mod_write & (soft_rst_q == `SOFT_RST_ARM) &
                      (pwdata[`SOFT_RST_HI:`SOFT_RST_LO] == `SOFT_RST_FIRE);

    // The shifter loads only on tx_load_shifter, whatever double_buffer_enable says;
    // without double buffering the empty flag still moves but carries no meaning.
    wire tx_load = tx_load_shifter & ~tx_empty_q;

    reg  [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        if (hit_mod) begin
            rd_mux[`TX_EMPTY_BIT] = tx_empty_q;
            rd_mux[`RX_FULL_BIT]  = rx_full_q;
            rd_mux[`TX_RUN_BIT]   = tx_run_q;
            rd_mux[`STOP_LEN_BIT] = stop_len_two;
            rd_mux[`DIR_BIT]      = msb_first;
            rd_mux[`DBUF_EN_BIT]  = double_buffer_enable;
            rd_mux[`SOFT_RST_HI:`SOFT_RST_LO] = soft_rst_q;
        end else if (hit_sts) begin
            rd_mux[`IRQ_WIDTH-1:0] = irq_status_q;
        end else if (hit_msk) begin
            rd_mux[`IRQ_WIDTH-1:0] = irq_mask_q;
        end else if (hit_txd) begin
            rd_mux[7:0] = tx_buf_q;
        end else if (hit_rxd) begin
            rd_mux[7:0] = rx_buf_q;
        end else if (hit_shf) begin
            rd_mux[7:0] = tx_shift_word;
        end
    end

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit_any;
            if (rd_stb) begin
                prdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Configuration and soft reset field
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            double_buffer_enable <= 1'b0;
            stop_len_two         <= 1'b0;
            msb_first            <= 1'b0;
            soft_rst_q           <= 2'h0;
            soft_reset_pulse     <= 1'b0;
        end else begin
            soft_reset_pulse <= soft_reset;
            if (mod_write) begin
                double_buffer_enable <= pwdata[`DBUF_EN_BIT];
                stop_len_two         <= pwdata[`STOP_LEN_BIT];
                msb_first            <= pwdata[`DIR_BIT];
                soft_rst_q           <= pwdata[`SOFT_RST_HI:`SOFT_RST_LO];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Buffer flags
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_empty_q    <= `TX_EMPTY_RESET;
            rx_full_q     <= `RX_FULL_RESET;
            tx_run_q      <= `TX_RUN_RESET;
            tx_buf_q      <= 8'h00;
            rx_buf_q      <= 8'h00;
            tx_shift_word <= 8'h00;
            tx_start      <= 1'b0;
        end else if (soft_reset) begin
            tx_empty_q <= `TX_EMPTY_RESET;
            rx_full_q  <= `RX_FULL_RESET;
            tx_run_q   <= `TX_RUN_RESET;
            tx_start   <= 1'b0;
        end else begin
            tx_start <= tx_load;
            if (tx_write) begin
                tx_buf_q   <= pwdata[7:0];
                tx_empty_q <= 1'b0;
            end else if (tx_load) begin
                tx_empty_q <= 1'b1;
            end
            if (tx_load) begin
                tx_shift_word <= tx_buf_q;
            end
            // A load in the same cycle as a finished word keeps the flag high, so running stays
            // visible regardless of the empty flag.
            if (tx_load) begin
                tx_run_q <= 1'b1;
            end else if (tx_shift_done) begin
                tx_run_q <= 1'b0;
            end
            // A word landing in the same cycle as the read wins, so no arrival is lost.
            if (rx_word_done) begin
                rx_buf_q  <= rx_shift_word;
                rx_full_q <= 1'b1;
            end else if (rx_read) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    wire [2:0] irq_event;
    assign irq_event[`IRQ_TX_EMPTY] = tx_load;
    assign irq_event[`IRQ_RX_FULL]  = rx_word_done;
    assign irq_event[`IRQ_TX_DONE]  = tx_shift_done & tx_run_q & ~tx_load;

    wire [2:0] sts_clear = (wr_stb & hit_sts) ? pwdata[2:0] : 3'h0;

    genvar i;
    generate
        for (i = 0; i < `IRQ_WIDTH; i = i + 1) begin : g_irq
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_status_q[i] <= 1'b0;
                end else if (irq_event[i]) begin
                    irq_status_q[i] <= 1'b1;
                end else if (sts_clear[i]) begin
                    irq_status_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= 3'h0;
            irq        <= 1'b0;
        end else begin
            if (wr_stb & hit_msk) begin
                irq_mask_q <= pwdata[2:0];
            end
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

endmodule

/* File: design/serial_buffer_status_flags_defs.vh */
// Overview of operation
// - Transmit-buffer-empty flag is read-only, 0 holding data, 1 empty, 1 after reset.
// - With double buffering off, the transmit-buffer-empty flag has no meaning.
// - Moving the buffered word into the transmit shifter sets transmit-buffer-empty.
// - Software writing new transmit data clears transmit-buffer-empty to zero.
// - Receive-buffer-full flag is read-only, 0 empty, 1 full; meaningless without double buffering.
// - A received word moved from shifter into the buffer sets receive-buffer-full.
// - Software reading the receive buffer clears receive-buffer-full.
// - Transmitting flag reads 1 while sending, 0 when stopped, whatever the empty flag says.
// - Transmitting 0 with empty 1 means done; with empty 0 means data waiting.
// - Writing 10 then 01 to the reset field reinitialises the three flags.
`ifndef SERIAL_BUFFER_STATUS_FLAGS_DEFS_VH
`define SERIAL_BUFFER_STATUS_FLAGS_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define MODE_CTRL_TWO_OFFSET  12'h000
`define IRQ_STATUS_OFFSET     12'h004
`define IRQ_MASK_OFFSET       12'h008
`define TX_DATA_OFFSET        12'h00c
`define RX_DATA_OFFSET        12'h010
`define SHIFTER_OFFSET        12'h014

// ----------------------------------------------------------------------------
// Field positions of the mode control register two
// ----------------------------------------------------------------------------
`define TX_EMPTY_BIT     7
`define RX_FULL_BIT      6
`define TX_RUN_BIT       5
`define STOP_LEN_BIT     4
`define DIR_BIT          3
`define DBUF_EN_BIT      2
`define SOFT_RST_HI      1
`define SOFT_RST_LO      0

`define SOFT_RST_ARM     2'h2
`define SOFT_RST_FIRE    2'h1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MODE_CFG_RESET   4'h0
`define TX_EMPTY_RESET   1'b1
`define RX_FULL_RESET    1'b0
`define TX_RUN_RESET     1'b0

// Interrupt bits: 0 transmit buffer emptied, 1 receive buffer filled, 2 transmission ended.
`define IRQ_TX_EMPTY     0
`define IRQ_RX_FULL      1
`define IRQ_TX_DONE      2
`define IRQ_WIDTH        3

`endif

/* File: tb/serial_buffer_status_flags_checker.sv */
`timescale 1ns/1ps
`include "serial_buffer_status_flags_defs.vh"
module serial_buffer_status_flags_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        tx_load_shifter,
    input wire        tx_start,
    input wire        soft_reset_pulse,
    input wire        irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer in the access cycle");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    chk_reserved_bits_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("reserved read bits not zero");
    chk_start_after_load: assert property (tx_start |-> $past(tx_load_shifter))
        else $error("start without a load request");
    chk_start_single: assert property (tx_start |=> !tx_start)
        else $error("start pulse too long");
    chk_soft_rst_cause: assert property (soft_reset_pulse |-> $past(psel && !penable && pwrite
        && paddr == `MODE_CTRL_TWO_OFFSET && pwdata[1:0] == `SOFT_RST_FIRE))
        else $error("soft reset without the firing write");
    chk_soft_rst_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse too long");

    cover property (soft_reset_pulse);
    cover property (tx_start);
    cover property (pready && pslverr);
    cover property (irq);
endmodule

bind serial_buffer_status_flags serial_buffer_status_flags_checker chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_load_shifter(tx_load_shifter), .tx_start(tx_start),
    .soft_reset_pulse(soft_reset_pulse), .irq(irq));

/* File: tb/serial_buffer_status_flags_tb.sv */
`timescale 1ns/1ps
`include "serial_buffer_status_flags_defs.vh"
module serial_buffer_status_flags_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_start, dbe, srp, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0]  ev;
    logic [7:0]  rx_w, tx_w, d;
    logic        sl, mf;
    logic [32:0] exp_q[$];
    logic [32:0] got;
    int          bad_count, comparisons;
    integer      seed = 32'hd8441880;

    serial_buffer_status_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_load_shifter(ev[0]), .tx_shift_done(ev[1]), .rx_word_done(ev[2]),
        .rx_shift_word(rx_w), .tx_shift_word(tx_w), .tx_start(tx_start), .double_buffer_enable(dbe),
        .stop_len_two(sl), .msb_first(mf), .soft_reset_pulse(srp), .irq(irq));

    task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Requests hold until ready is seen at a rising edge, for at most 20 edges; one idle edge separates transfers.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev <= 3'h0;
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            got = exp_q.pop_front();
            chk("read", {pslverr, prdata}, got);
        end
    end

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        repeat (4000) @(posedge pclk);
        bad_count++;
        end_sim;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ev, rx_w} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`MODE_CTRL_TWO_OFFSET, 33'h80);
        apb(1'b1, `MODE_CTRL_TWO_OFFSET, 32'hffffff3c);
        rd(`MODE_CTRL_TWO_OFFSET, 33'h9c);
        chk("dbuf", {32'h0, dbe}, 33'h1);
        chk("stop len", {32'h0, sl}, 33'h1);
        chk("msb first", {32'h0, mf}, 33'h1);
        $display("test reset and access done");
        d = 8'($random(seed));
        apb(1'b1, `TX_DATA_OFFSET, {24'h0, d});
        rd(`MODE_CTRL_TWO_OFFSET, 33'h1c);
        pulse(0);
        @(negedge pclk);
        chk("shift word", {25'h0, tx_w}, {25'h0, d});
        chk("tx start", {32'h0, tx_start}, 33'h1);
        rd(`MODE_CTRL_TWO_OFFSET, 33'hbc);
        pulse(1);
        rd(`MODE_CTRL_TWO_OFFSET, 33'h9c);
        $display("test transmit done");
        rx_w <= 8'($random(seed));
        pulse(2);
        rd(`MODE_CTRL_TWO_OFFSET, 33'hdc);
        rd(`RX_DATA_OFFSET, {25'h0, rx_w});
        rd(`MODE_CTRL_TWO_OFFSET, 33'h9c);
        $display("test receive done");
        rd(`IRQ_STATUS_OFFSET, 33'h7);
        chk("irq masked", {32'h0, irq}, 33'h0);
        apb(1'b1, `IRQ_MASK_OFFSET, 32'h2);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("irq raised", {32'h0, irq}, 33'h1);
        apb(1'b1, `IRQ_STATUS_OFFSET, 32'h2);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("irq cleared", {32'h0, irq}, 33'h0);
        rd(`IRQ_STATUS_OFFSET, 33'h5);
        $display("test interrupt done");
        apb(1'b1, `TX_DATA_OFFSET, 32'h5a);
        pulse(0);
        apb(1'b1, `TX_DATA_OFFSET, 32'ha5);
        pulse(2);
        apb(1'b1, `MODE_CTRL_TWO_OFFSET, 32'h6);
        apb(1'b1, `MODE_CTRL_TWO_OFFSET, 32'h5);
        rd(`MODE_CTRL_TWO_OFFSET, 33'h85);
        $display("test soft reset done");
        rd(12'h100, 33'h100000000);
        apb(1'b1, 12'h100, 32'hffffffff);
        rd(`IRQ_MASK_OFFSET, 33'h2);
        $display("test unmapped done");
        end_sim;
    end
endmodule
